// ---- rtl/sprc_top.v ----
/*
 Rate and format configuration of the main serial port and the
 configuration/debug port: holding registers, rate hunt, settings that
 apply at restart, and a reply FIFO held back until the rate is locked.
 Assumes a protocol engine on clk_sys that owns the holding register
 port and a character engine that uses the tick and format outputs.
*/
`include "sprc_regs.vh"

module sprc_top #(
   parameter CLK_HZ     = `SPRC_CLK_HZ,
   parameter HUNT_BITS  = 2000,
   parameter FIFO_W     = 8,
   parameter FIFO_DEPTH = 32
) (
   // Clock and reset
   input  wire              clk_sys,
   input  wire              rst,
   // Holding register port
   input  wire [15:0]       reg_addr,
   input  wire              reg_wr,
   input  wire [15:0]       reg_wdata,
   input  wire              reg_rd,
   output reg  [15:0]       reg_rdata,
   output reg               reg_rvalid,
   output reg               reg_err,
   // Receive frame verdicts from the protocol engine
   input  wire              rx_frame_ok,
   input  wire              rx_frame_bad,
   // Reply bytes from the protocol engine
   input  wire [FIFO_W-1:0] tx_in_data,
   input  wire              tx_in_valid,
   output wire              tx_in_ready,
   // Reply bytes to the character engine
   output wire [FIFO_W-1:0] tx_out_data,
   output wire              tx_out_valid,
   input  wire              tx_out_ready,
   // Main serial port character format
   output wire              main_bit_tick,
   output reg  [2:0]        main_rate_code,
   output reg               main_rate_locked,
   output reg               main_parity_en,
   output reg               main_parity_odd,
   output reg               main_stop_two,
   output wire [3:0]        main_data_bits,
   // Config/debug port character format
   output wire              dbg_bit_tick,
   output reg  [2:0]        dbg_rate_code,
   output reg               dbg_cfg_fallback,
   output wire              dbg_parity_en,
   output wire              dbg_parity_odd,
   output wire              dbg_stop_two
);
   localparam ST_APPLY = 3'b001;
   localparam ST_HUNT  = 3'b010;
   localparam ST_LOCK  = 3'b100;
   localparam HUNT_W   = 16;
   localparam integer HUNT_END = HUNT_BITS - 1;
   // Window counter is 16 bits; HUNT_BITS above 65536 is not supported
   localparam [HUNT_W-1:0] HUNT_LAST = HUNT_END[HUNT_W-1:0];

   // Stored settings, as software last wrote them; refused main values leave the old ones
   reg  [15:0]       main_rate_sel_q;
   reg  [15:0]       main_par_sel_q;
   reg  [15:0]       dbg_rate_sel_q;
   // Settings in force since the last restart
   reg  [15:0]       act_par_q;
   reg  [2:0]        state_q;
   reg  [2:0]        state_d;
   reg  [2:0]        try_q;
   reg  [2:0]        try_d;
   reg  [HUNT_W-1:0] hunt_q;
   reg  [HUNT_W-1:0] hunt_d;
   reg  [2:0]        lock_q;
   reg  [2:0]        lock_d;
   reg               restart_q;
   wire              wr_main_rate;
   wire              wr_main_par;
   wire              wr_dbg_rate;
   wire              fifo_in_valid;
   wire              fifo_in_ready;
   wire              fifo_out_valid;
   wire [15:0]       rate_cur;

   function is_mapped;
      input [15:0] a;
      begin
         is_mapped = (a == `SPRC_REG_CMD) || (a == `SPRC_REG_MAIN_RATE) ||
                     (a == `SPRC_REG_MAIN_PAR) || (a == `SPRC_REG_MAIN_CUR) ||
                     (a == `SPRC_REG_DBG_RATE);
      end
   endfunction

   function dbg_code_ok;
      input [15:0] v;
      begin
         dbg_code_ok = (v >= {13'h0000, `SPRC_RATE_2400}) &&
                       (v <= {13'h0000, `SPRC_RATE_115200});
      end
   endfunction

   assign wr_main_rate = reg_wr && (reg_addr == `SPRC_REG_MAIN_RATE);
   assign wr_main_par  = reg_wr && (reg_addr == `SPRC_REG_MAIN_PAR);
   assign wr_dbg_rate  = reg_wr && (reg_addr == `SPRC_REG_DBG_RATE);

   // Holding registers; out-of-range main values are refused whole
   always @(posedge clk_sys) begin
      if (rst) begin
         main_rate_sel_q <= `SPRC_RST_MAIN_RATE;
         main_par_sel_q  <= `SPRC_RST_MAIN_PAR;
         dbg_rate_sel_q  <= `SPRC_RST_DBG_RATE;
         restart_q       <= 1'b0;
      end else begin
         if (wr_main_rate && reg_wdata <= {13'h0000, `SPRC_RATE_115200})
            main_rate_sel_q <= reg_wdata;
         if (wr_main_par && reg_wdata <= `SPRC_PAR_NONE)
            main_par_sel_q <= reg_wdata;
         if (wr_dbg_rate)
            dbg_rate_sel_q <= reg_wdata;
         restart_q <= reg_wr && (reg_addr == `SPRC_REG_CMD) &&
                      (reg_wdata == `SPRC_CMD_RESTART);
      end
   end

   // Reads answer one cycle later; unmapped numbers read zero with error
   assign rate_cur = {13'h0000, lock_q};
   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata  <= 16'h0000;
         reg_rvalid <= 1'b0;
         reg_err    <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         reg_err    <= reg_rd && !is_mapped(reg_addr);
         if (reg_rd) begin
            case (reg_addr)
               `SPRC_REG_MAIN_RATE: reg_rdata <= main_rate_sel_q;
               `SPRC_REG_MAIN_PAR:  reg_rdata <= main_par_sel_q;
               `SPRC_REG_MAIN_CUR:  reg_rdata <= rate_cur;
               `SPRC_REG_DBG_RATE:  reg_rdata <= dbg_rate_sel_q;
               default:             reg_rdata <= 16'h0000;
            endcase
         end
      end
   end

   // Main parity setting is copied only here, so a write alone changes nothing
   always @(posedge clk_sys) begin
      if (rst) begin
         act_par_q  <= `SPRC_RST_MAIN_PAR;
      end else if (state_q == ST_APPLY) begin
         // Rate choice is taken by the hunt machine in this same cycle
         act_par_q  <= main_par_sel_q;
      end
   end

   // Rate hunt: a bad frame or a quiet window moves to the next rate
   always @* begin
      state_d = state_q;
      try_d   = try_q;
      hunt_d  = hunt_q;
      lock_d  = lock_q;
      case (state_q)
         ST_APPLY: begin
            hunt_d = {HUNT_W{1'b0}};
            try_d  = `SPRC_RATE_2400;
            if (main_rate_sel_q[2:0] == `SPRC_RATE_AUTO) begin
               state_d = ST_HUNT;
               lock_d  = `SPRC_RATE_UNKNOWN;
            end else begin
               state_d = ST_LOCK;
               lock_d  = main_rate_sel_q[2:0];
            end
         end
         ST_HUNT: begin
            if (rx_frame_ok) begin
               state_d = ST_LOCK;
               lock_d  = try_q;
            end else if (rx_frame_bad ||
                         (main_bit_tick && hunt_q == HUNT_LAST)) begin
               // Wraps from 115200 back to 2400; master keeps polling
               try_d  = (try_q == `SPRC_RATE_115200) ?
                        `SPRC_RATE_2400 : try_q + 3'h1;
               hunt_d = {HUNT_W{1'b0}};
            end else if (main_bit_tick) begin
               hunt_d = hunt_q + 1'b1;
            end
         end
         ST_LOCK: begin
            state_d = ST_LOCK;
         end
         default: begin
            state_d = ST_APPLY;
         end
      endcase
      if (restart_q)
         state_d = ST_APPLY;
   end

   always @(posedge clk_sys) begin
      if (rst) begin
         state_q <= ST_APPLY;
         try_q   <= `SPRC_RATE_2400;
         hunt_q  <= {HUNT_W{1'b0}};
         lock_q  <= `SPRC_RATE_UNKNOWN;
      end else begin
         state_q <= state_d;
         try_q   <= try_d;
         hunt_q  <= hunt_d;
         lock_q  <= lock_d;
      end
   end

   // Main port format; parity and stop bits trade off to fixed length
   always @(posedge clk_sys) begin
      if (rst) begin
         main_rate_code   <= `SPRC_RATE_2400;
         main_rate_locked <= 1'b0;
         main_parity_en   <= 1'b1;
         main_parity_odd  <= 1'b0;
         main_stop_two    <= 1'b0;
      end else begin
         // APPLY keeps the old code, so code 0 never reaches the divider
         if (state_d == ST_HUNT)
            main_rate_code <= try_d;
         else if (state_d == ST_LOCK)
            main_rate_code <= lock_d;
         main_rate_locked <= (state_d == ST_LOCK);
         main_parity_en   <= (act_par_q != `SPRC_PAR_NONE);
         main_parity_odd  <= (act_par_q == `SPRC_PAR_ODD);
         main_stop_two    <= (act_par_q == `SPRC_PAR_NONE);
      end
   end

   assign main_data_bits = `SPRC_DATA_BITS;

   // Debug port: fixed rate from the stored code, checked at restart
   always @(posedge clk_sys) begin
      if (rst) begin
         dbg_rate_code    <= `SPRC_RATE_115200;
         dbg_cfg_fallback <= 1'b0;
      end else if (state_q == ST_APPLY) begin
         if (dbg_code_ok(dbg_rate_sel_q)) begin
            dbg_rate_code    <= dbg_rate_sel_q[2:0];
            dbg_cfg_fallback <= 1'b0;
         end else begin
            dbg_rate_code    <= `SPRC_RATE_115200;
            dbg_cfg_fallback <= 1'b1;
         end
      end
   end

   // Fallback format also used as the fixed debug format
   assign dbg_parity_en  = 1'b1;
   assign dbg_parity_odd = 1'b0;
   assign dbg_stop_two   = 1'b0;

   sprc_baud #(
      .CLK_HZ   (CLK_HZ)
   ) u_main_baud (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .code     (main_rate_code),
      .bit_tick (main_bit_tick)
   );

   sprc_baud #(
      .CLK_HZ   (CLK_HZ)
   ) u_dbg_baud (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .code     (dbg_rate_code),
      .bit_tick (dbg_bit_tick)
   );

   // Replies built while hunting are dropped, not queued, so no stale
   // answer escapes at the moment of lock
   assign fifo_in_valid = tx_in_valid && main_rate_locked;
   assign tx_in_ready   = main_rate_locked ? fifo_in_ready : 1'b1;
   assign tx_out_valid  = fifo_out_valid && main_rate_locked;

   sprc_fifo #(
      .WIDTH     (FIFO_W),
      .DEPTH     (FIFO_DEPTH)
   ) u_tx_fifo (
      .clk_sys   (clk_sys),
      .rst       (rst),
      .clr       (!main_rate_locked),
      .in_data   (tx_in_data),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .out_data  (tx_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (tx_out_ready && main_rate_locked)
   );
endmodule // sprc_top

// ---- rtl/sprc_regs.vh ----
/*
 Constants of the serial port rate and format configuration block:
 holding register numbers, field codes, reset values and bitrates.
 Assumes inclusion by bare name from the design files of this block.
*/
`ifndef SPRC_REGS_VH
`define SPRC_REGS_VH

// Holding register numbers
`define SPRC_REG_CMD          16'h0001
`define SPRC_REG_MAIN_RATE    16'h0005
`define SPRC_REG_MAIN_PAR     16'h0006
`define SPRC_REG_MAIN_CUR     16'h0007
`define SPRC_REG_DBG_RATE     16'h0012

// Command value that restarts the module
`define SPRC_CMD_RESTART      16'h0003

// Rate codes
`define SPRC_RATE_AUTO        3'h0
`define SPRC_RATE_2400        3'h1
`define SPRC_RATE_4800        3'h2
`define SPRC_RATE_9600        3'h3
`define SPRC_RATE_19200       3'h4
`define SPRC_RATE_38400       3'h5
`define SPRC_RATE_57600       3'h6
`define SPRC_RATE_115200      3'h7
`define SPRC_RATE_UNKNOWN     3'h0

// Bitrates in bit/s
`define SPRC_BPS_2400         2400
`define SPRC_BPS_4800         4800
`define SPRC_BPS_9600         9600
`define SPRC_BPS_19200        19200
`define SPRC_BPS_38400        38400
`define SPRC_BPS_57600        57600
`define SPRC_BPS_115200       115200

// Parity codes of the main port
`define SPRC_PAR_EVEN         16'h0000
`define SPRC_PAR_ODD          16'h0001
`define SPRC_PAR_NONE         16'h0002

// Reset values
`define SPRC_RST_MAIN_RATE    16'h0000
`define SPRC_RST_MAIN_PAR     16'h0000
`define SPRC_RST_DBG_RATE     16'h0007

// Character format and default system clock frequency in Hz
`define SPRC_DATA_BITS        4'h8
`define SPRC_CLK_HZ           200000000

`endif

// ---- rtl/sprc_fifo.v ----
/*
 Synchronous FIFO of flip-flops with valid and ready on both sides.
 Assumes one clock, a synchronous active-high reset and a clear input
 on the same clock.
*/
module sprc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = 32
) (
   // Clock and reset
   input  wire             clk_sys,
   input  wire             rst,
   input  wire             clr,
   // Fill side
   input  wire [WIDTH-1:0] in_data,
   input  wire             in_valid,
   output wire             in_ready,
   // Drain side
   output wire [WIDTH-1:0] out_data,
   output wire             out_valid,
   input  wire             out_ready
);
   function integer clog2;
      input integer v;
      integer n;
      begin
         n = 0;
         while ((1 << n) < v)
            n = n + 1;
         clog2 = (n < 1) ? 1 : n;
      end
   endfunction

   localparam AW = clog2(DEPTH);

   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0]    wr_q;
   reg [AW-1:0]    rd_q;
   reg [AW:0]      cnt_q;
   wire            push;
   wire            pop;

   assign in_ready  = (cnt_q != DEPTH[AW:0]);
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign out_data  = mem_q[rd_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // Pointers wrap by hand so that DEPTH need not be a power of two
   always @(posedge clk_sys) begin
      if (rst || clr) begin
         wr_q  <= {AW{1'b0}};
         rd_q  <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
         if (pop)
            rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
         if (push && !pop)
            cnt_q <= cnt_q + 1'b1;
         else if (pop && !push)
            cnt_q <= cnt_q - 1'b1;
      end
   end

   always @(posedge clk_sys) begin
      if (push)
         mem_q[wr_q] <= in_data;
   end
endmodule // sprc_fifo

// ---- rtl/sprc_baud.v ----
/*
 Bit-rate enable generator: one pulse of clk_sys per bit time for the
 selected rate code. Assumes the code is held steady by its owner; a
 change restarts the count.
*/
`include "sprc_regs.vh"

module sprc_baud #(
   parameter CLK_HZ = `SPRC_CLK_HZ,
   parameter DIV_W  = 17
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst,
   // Rate code, 1 to 7
   input  wire [2:0] code,
   // One pulse per bit time
   output reg        bit_tick
);
   reg [DIV_W-1:0] cnt_q;
   reg [2:0]       code_q;

   function [DIV_W-1:0] rate_div;
      input [2:0] c;
      integer bps;
      integer tmp;
      begin
         case (c)
            `SPRC_RATE_2400:  bps = `SPRC_BPS_2400;
            `SPRC_RATE_4800:  bps = `SPRC_BPS_4800;
            `SPRC_RATE_9600:  bps = `SPRC_BPS_9600;
            `SPRC_RATE_19200: bps = `SPRC_BPS_19200;
            `SPRC_RATE_38400: bps = `SPRC_BPS_38400;
            `SPRC_RATE_57600: bps = `SPRC_BPS_57600;
            default:          bps = `SPRC_BPS_115200;
         endcase
         tmp      = CLK_HZ / bps;
         rate_div = tmp[DIV_W-1:0];
      end
   endfunction

   always @(posedge clk_sys) begin
      if (rst) begin
         cnt_q    <= {DIV_W{1'b0}};
         code_q   <= `SPRC_RATE_115200;
         bit_tick <= 1'b0;
      end else begin
         code_q <= code;
         if (code != code_q || cnt_q == rate_div(code) - 1'b1) begin
            cnt_q    <= {DIV_W{1'b0}};
            bit_tick <= (code == code_q);
         end else begin
            cnt_q    <= cnt_q + 1'b1;
            bit_tick <= 1'b0;
         end
      end
   end
endmodule // sprc_baud

// ---- bench/sprc_top_sva.sv ----
/* Port checker for sprc_top.
   Assumes binding to sprc_top, one clock, synchronous active-high rst. */
module sprc_chk (
   // Clock and reset
   input logic        clk_sys,
   input logic        rst,
   // Register port
   input logic [15:0] reg_addr,
   input logic        reg_wr,
   input logic [15:0] reg_wdata,
   input logic        reg_rd,
   input logic [15:0] reg_rdata,
   input logic        reg_rvalid,
   input logic        reg_err,
   // Verdicts and replies
   input logic        rx_frame_ok,
   input logic        rx_frame_bad,
   input logic        tx_out_valid,
   // Main port format
   input logic        main_bit_tick,
   input logic [2:0]  main_rate_code,
   input logic        main_rate_locked,
   input logic        main_parity_en,
   input logic        main_parity_odd,
   input logic        main_stop_two,
   input logic [3:0]  main_data_bits,
   // Debug port format
   input logic [2:0]  dbg_rate_code,
   input logic        dbg_cfg_fallback,
   input logic        dbg_parity_en,
   input logic        dbg_parity_odd,
   input logic        dbg_stop_two
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   logic [2:0] age_q;
   // Cycles since restart; rst counts as one
   always_ff @(posedge clk_sys)
      if (rst || (reg_wr && reg_addr == 16'h0001 && reg_wdata == 16'h0003))
         age_q <= 3'h0;
      else if (age_q != 3'h7)
         age_q <= age_q + 3'h1;
   // Three idle cycles skip the apply cycle after a restart
   sequence hunting_s;
      !main_rate_locked [*3];
   endsequence
   read_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   hunt_zero_a: assert property (hunting_s ##0 (reg_rd &&
      reg_addr == 16'h0007 && !rx_frame_ok) |=> reg_rdata == 16'h0000)
      else $error("current rate not zero while hunting");
   silent_hunt_a: assert property (!main_rate_locked |-> !tx_out_valid)
      else $error("reply offered while hunting");
   hunt_lock_a: assert property (hunting_s ##0 rx_frame_ok |=>
      main_rate_locked && $stable(main_rate_code))
      else $error("good frame did not lock");
   hunt_step_a: assert property (hunting_s ##0 (rx_frame_bad &&
      !rx_frame_ok) |=> main_rate_code == ($past(main_rate_code) == 3'h7
      ? 3'h1 : $past(main_rate_code) + 3'h1))
      else $error("hunt did not step to next rate");
   late_apply_a: assert property ($changed(main_parity_odd) ||
      $changed(main_stop_two) |-> age_q < 3'h5)
      else $error("format changed without restart");
   equal_len_a: assert property (main_parity_en != main_stop_two)
      else $error("character length varies");
   odd_par_a: assert property (main_parity_odd |-> main_parity_en)
      else $error("odd parity without parity");
   rate_code_a: assert property (main_rate_code != 3'h0 &&
      dbg_rate_code != 3'h0)
      else $error("rate code zero in use");
   data_bits_a: assert property (main_data_bits == 4'h8)
      else $error("data bits not eight");
   dbg_fallback_a: assert property (dbg_cfg_fallback |->
      dbg_rate_code == 3'h7 && dbg_parity_en && !dbg_parity_odd
      && !dbg_stop_two)
      else $error("debug fallback format wrong");
   tick_gap_a: assert property (main_bit_tick |=> !main_bit_tick [*8])
      else $error("bit ticks too close");
endmodule // sprc_chk

// ---- bench/sprc_master_model.sv ----
/* Far-side bus master: polls while the device hunts, takes replies.
   Assumes the bench gives the rate the master really talks at. */
module sprc_master_model #(
   parameter int POLL_GAP = 50
) (
   // Clock and reset
   input  logic       clk_sys,
   input  logic       rst,
   // Master line rate and stall request
   input  logic [2:0] true_code,
   input  logic       hold_off,
   // Device side
   input  logic [2:0] main_rate_code,
   input  logic       main_rate_locked,
   output logic       rx_frame_ok,
   output logic       rx_frame_bad,
   output logic       tx_out_ready
);
   int   gap = 0;
   logic fire;
   logic [7:0] lfsr = 8'h5a;
   initial {rx_frame_ok, rx_frame_bad, tx_out_ready} = 3'b000;
   // Frames decode only when both ends share a rate
   always @(negedge clk_sys) begin
      fire = !rst && !main_rate_locked && gap == POLL_GAP;
      rx_frame_ok <= fire && main_rate_code == true_code;
      rx_frame_bad <= fire && main_rate_code != true_code;
      // Unanswered polls repeat until the device locks
      gap <= (rst || main_rate_locked || fire) ? 0 : gap + 1;
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
      // Slow taker, stalls about half the cycles
      tx_out_ready <= !hold_off && lfsr[0];
   end
endmodule // sprc_master_model

// ---- bench/sprc_top_tb_top.sv ----
/* Self-checking bench of sprc_top with the far-side master model.
   Assumes the checker and master model are compiled first. */
module sprc_top_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, reg_rdata;
   logic        reg_rvalid, reg_err, rx_frame_ok, rx_frame_bad;
   logic [7:0]  tx_in_data = 8'h0, tx_out_data;
   logic        tx_in_valid = 1'b0, tx_in_ready, tx_out_valid;
   logic        tx_out_ready, hold_off = 1'b1, main_bit_tick, dbg_bit_tick;
   logic        main_rate_locked, main_parity_en, main_parity_odd;
   logic        main_stop_two, dbg_cfg_fallback, dbg_parity_en;
   logic        dbg_parity_odd, dbg_stop_two;
   logic [2:0]  main_rate_code, dbg_rate_code, true_code = 3'h1;
   logic [3:0]  main_data_bits;
   logic [31:0] seed = 32'd16788;
   logic [16:0] rd_q[$];
   logic [7:0]  tx_q[$];
   int          fails = 0, n_checks = 0;
   int          dbg_gap = 0, dbg_per = 0;
   always #2.5 clk_sys = ~clk_sys;
   sprc_top #(.CLK_HZ(1152000), .HUNT_BITS(20)) dut (.clk_sys(clk_sys),
      .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .reg_err(reg_err),
      .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad),
      .tx_in_data(tx_in_data), .tx_in_valid(tx_in_valid),
      .tx_in_ready(tx_in_ready), .tx_out_data(tx_out_data),
      .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready),
      .main_bit_tick(main_bit_tick), .main_rate_code(main_rate_code),
      .main_rate_locked(main_rate_locked), .main_parity_en(main_parity_en),
      .main_parity_odd(main_parity_odd), .main_stop_two(main_stop_two),
      .main_data_bits(main_data_bits), .dbg_bit_tick(dbg_bit_tick),
      .dbg_rate_code(dbg_rate_code), .dbg_cfg_fallback(dbg_cfg_fallback),
      .dbg_parity_en(dbg_parity_en), .dbg_parity_odd(dbg_parity_odd),
      .dbg_stop_two(dbg_stop_two));
   sprc_master_model u_master (.clk_sys(clk_sys), .rst(rst),
      .true_code(true_code), .hold_off(hold_off),
      .main_rate_code(main_rate_code), .main_rate_locked(main_rate_locked),
      .rx_frame_ok(rx_frame_ok), .rx_frame_bad(rx_frame_bad),
      .tx_out_ready(tx_out_ready));
   function automatic logic [31:0] xrand();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [16:0] seen, input logic [16:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      @(negedge clk_sys);
      {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
      @(negedge clk_sys);
      reg_wr = 1'b0;
   endtask
   // Expected answer is {err, data}
   task automatic rd(input logic [15:0] a, input logic [16:0] exp);
      @(negedge clk_sys);
      {reg_addr, reg_rd} = {a, 1'b1};
      rd_q.push_back(exp);
      @(negedge clk_sys);
      reg_rd = 1'b0;
   endtask
   task automatic restart();
      wr(16'h0001, 16'h0003);
      repeat (6) @(negedge clk_sys);
   endtask
   task automatic wait_lock();
      int i;
      for (i = 0; i < 3000 && main_rate_locked !== 1'b1; i++)
         @(negedge clk_sys);
      if (i == 3000) begin
         fails++;
         print_verdict();
      end
   endtask
   // Results are compared in order of their notes
   always @(posedge clk_sys) begin
      if (reg_rvalid === 1'b1)
         check({reg_err, reg_rdata}, rd_q.size() ? rd_q.pop_front() : '1);
      if (tx_out_valid === 1'b1 && tx_out_ready === 1'b1)
         check(tx_out_data, tx_q.size() ? tx_q.pop_front() : '1);
      // Debug bit period in clock cycles, tick to tick
      dbg_gap <= (dbg_bit_tick === 1'b1) ? 1 : dbg_gap + 1;
      if (dbg_bit_tick === 1'b1)
         dbg_per <= dbg_gap;
   end
   initial begin
      true_code = 3'(xrand() % 7) + 3'h1;
      repeat (5) @(negedge clk_sys);
      rst = 1'b0;
      rd(16'h0005, 17'h0);
      rd(16'h0006, 17'h0);
      rd(16'h0007, 17'h0);
      rd(16'h0012, 17'h7);
      rd(16'h0003, 17'h10000);
      tx_in_valid = 1'b1;
      #1 check(tx_in_ready, 1'b1);
      wait_lock();
      tx_in_valid = 1'b0;
      rd(16'h0007, {14'h0, true_code});
      wr(16'h0006, 16'h0001);
      wr(16'h0007, 16'h0005);
      wr(16'h0005, 16'h0009);
      check(main_parity_odd, 1'b0);
      rd(16'h0005, 17'h0);
      rd(16'h0007, {14'h0, true_code});
      for (int c = 1; c < 8; c++) begin
         wr(16'h0005, 16'(c));
         wr(16'h0006, 16'(c % 3));
         restart();
         check({main_rate_locked, main_rate_code}, {1'b1, 3'(c)});
         check({main_parity_en, main_parity_odd, main_stop_two},
            c % 3 == 0 ? 3'b100 : c % 3 == 1 ? 3'b110 : 3'b001);
         rd(16'h0007, 17'(c));
      end
      wr(16'h0012, 16'h0000);
      restart();
      check({dbg_cfg_fallback, dbg_rate_code}, 4'hf);
      wr(16'h0012, 16'h0003);
      rd(16'h0012, 17'h3);
      check(dbg_rate_code, 3'h7);
      restart();
      check({dbg_cfg_fallback, dbg_rate_code}, 4'h3);
      // Fill past capacity with the taker stalled
      for (int i = 0; i < 33; i++) begin
         @(negedge clk_sys);
         tx_in_data = 8'(xrand());
         tx_in_valid = 1'b1;
         #1 if (tx_in_ready === 1'b1) tx_q.push_back(tx_in_data);
      end
      @(negedge clk_sys);
      tx_in_valid = 1'b0;
      check(tx_q.size(), 32);
      hold_off = 1'b0;
      for (int i = 0; i < 500 && tx_q.size() != 0; i++) @(negedge clk_sys);
      check({tx_q.size() != 0, tx_out_valid}, 2'b00);
      if (tx_q.size() != 0)
         print_verdict();
      // Debug port still at code 3 from the last restart
      repeat (250) @(negedge clk_sys);
      check(17'(dbg_per), 17'(1152000 / 9600));
      // Second hunt's true rate is above the lowest rate, so bad frames step it
      true_code = 3'(xrand() % 6) + 3'h2;
      wr(16'h0005, 16'h0000);
      restart();
      rd(16'h0007, 17'h0);
      check(main_rate_locked, 1'b0);
      wait_lock();
      rd(16'h0007, {14'h0, true_code});
      @(negedge clk_sys);
      check(rd_q.size(), 0);
      print_verdict();
   end
endmodule // sprc_top_tb_top
bind sprc_top sprc_chk u_chk (.clk_sys(clk_sys), .rst(rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .reg_err(reg_err), .rx_frame_ok(rx_frame_ok),
   .rx_frame_bad(rx_frame_bad), .tx_out_valid(tx_out_valid),
   .main_bit_tick(main_bit_tick), .main_rate_code(main_rate_code),
   .main_rate_locked(main_rate_locked), .main_parity_en(main_parity_en),
   .main_parity_odd(main_parity_odd), .main_stop_two(main_stop_two),
   .main_data_bits(main_data_bits), .dbg_rate_code(dbg_rate_code),
   .dbg_cfg_fallback(dbg_cfg_fallback), .dbg_parity_en(dbg_parity_en),
   .dbg_parity_odd(dbg_parity_odd), .dbg_stop_two(dbg_stop_two));
